// [design/dtu_debug_event_trigger_unit.sv]
`timescale 1ns/10ps
`default_nettype none
`include "dtu_defs.svh"

// Summary of operation
// - With debug enabled, break-in, debug instruction, register moves and triggers raise events
// - Break-in recognition waits while a non-cancellable multi-cycle operation runs
// - Break-in event takes actions from the external event configuration
// - With debug disabled, debug instruction yields no event and no effect
// - Short and long debug instruction encodings behave identically
// - Debug instruction event takes actions from the software event configuration
// - Move to or from a user core register raises an event
// - No register access event inside the debug register window F000 to FDFF
// - Debug controller setup and performance counter accesses never raise events
// - Register access event takes actions from the register access configuration
// - Triggers compare virtual fetch and data addresses only
// - Trigger event takes actions from the firing trigger's configuration
// - Each trigger has address and configuration; exec, load, store, single or range
// - Range fires when address at least even address and below odd address
// - With even range bit set, odd partner configuration is ignored entirely
// - Up to four ranges from pairs 0/1 to 6/7, enabled by even member
// - Range bit of odd triggers is reserved and has no effect
// - With task qualify set, trigger needs address match and task identifier match
// - Every activation sets its record bit; ranges record lower trigger only
// - Record is read only, cleared by any read, writes ignored
// - Each event performs the actions selected by its configuration
// - Debug disabled while enable bit zero, enabled while one, driven externally
// - Each event updates source and posted status; previous suspend and suspend also, except for interrupt actions
module dtu_debug_event_trigger_unit #(
	parameter int NTRIG = 8,
	parameter int AW    = 32,
	parameter int TIDW  = 8
) (
	input  wire logic                                clk,
	input  wire logic                                nrst,
	input  wire logic                                debugEnable,
	input  wire logic                                breakIn,
	input  wire logic                                nonCancelBusy,
	input  wire logic                                instrValid,
	input  wire logic [31:0]                         instrWord,
	input  wire logic                                instrIsShort,
	input  wire logic                                coreRegAccess,
	input  wire logic [15:0]                         coreRegAddr,
	input  wire logic                                fetchValid,
	input  wire logic [AW-1:0]                       fetchVaddr,
	input  wire logic                                loadValid,
	input  wire logic                                storeValid,
	input  wire logic [AW-1:0]                       dataVaddr,
	input  wire logic [TIDW-1:0]                     currentTaskIdentifier,
	input  wire logic [`DTU_CFG_W-1:0]               externalEventConfig,
	input  wire logic [`DTU_CFG_W-1:0]               softwareEventConfig,
	input  wire logic [`DTU_CFG_W-1:0]               coreRegAccessEventConfig,
	input  wire logic [NTRIG*AW-1:0]                 triggerAddress,
	input  wire logic [NTRIG*`DTU_TCFG_W-1:0]        triggerEventConfig,
	input  wire logic [NTRIG*TIDW-1:0]               triggerTaskIdentifier,
	input  wire logic                                recordRead,
	output logic [NTRIG-1:0]                         accumulatedTriggerRecord,
	output logic                                     debugEvent,
	output logic [`DTU_SRC_W-1:0]                    eventSource,
	output logic                                     postedEvent,
	output logic                                     prevSuspend,
	output logic                                     suspendOut,
	output logic                                     breakOut,
	output logic                                     haltReq,
	output logic                                     trapReq,
	output logic [3:0]                               bkptIrq,
	output logic                                     counterToggle,
	output logic                                     suspendInHaltEn,
	output logic                                     breakBeforeMake
);
	import dtu_pkg::*;

	// Elaboration check: even trigger count, two to eight
	if (NTRIG < 2 || NTRIG > 8 || NTRIG % 2 != 0 || AW < 1 || TIDW < 1)
		$error("dtu: unsupported parameters");

	typedef struct packed {
		// Break-in synchroniser and pending flag
		logic [2:0]             brkSync;
		logic                   brkPend;
		// Accumulated trigger record
		logic [NTRIG-1:0]       rec;
		// Debug status
		logic                   evt;
		logic [`DTU_SRC_W-1:0]  src;
		logic                   posted;
		logic                   prevSusp;
		logic                   susp;
		// Action outputs
		logic                   brkOut;
		logic                   halt;
		logic                   trap;
		logic [3:0]             irq;
		logic                   cnt;
		logic                   suspInHalt;
		logic                   bbm;
		dtu_state_t             state;
	} dtu_state_s_t;

	dtu_state_s_t st_reg;
	dtu_state_s_t st_next;

	logic [NTRIG-1:0] hit;
	logic [NTRIG-1:0] actv;
	logic             brkRise;
	logic             swHit;
	logic             crHit;
	logic [`DTU_CFG_W-1:0] cfg;
	logic [`DTU_SRC_W-1:0] srcSel;
	logic             anyEvt;
	// Trigger compare terms
	logic [NTRIG-1:0] execSel;
	logic [NTRIG-1:0] dataSel;
	logic [NTRIG-1:0] execEq;
	logic [NTRIG-1:0] dataEq;
	logic [NTRIG-1:0] execIn;
	logic [NTRIG-1:0] dataIn;
	logic [NTRIG-1:0] rngEn;
	logic [NTRIG-1:0] taskOk;
	// Instruction and register move decode
	logic             inDbgWin;
	logic             inPerfWin;
	logic             shortHit;
	logic             longHit;
	dtu_act_t         act;

	// Per-trigger compare terms
	always_comb begin
		execSel = '0;
		dataSel = '0;
		execEq = '0;
		dataEq = '0;
		rngEn = '0;
		taskOk = '0;
		for (int i = 0; i < NTRIG; i++) begin
			execSel[i] = triggerEventConfig[i*`DTU_TCFG_W + `DTU_TEN_EXEC] && fetchValid;
			dataSel[i] = (triggerEventConfig[i*`DTU_TCFG_W + `DTU_TEN_LOAD] && loadValid)
				|| (triggerEventConfig[i*`DTU_TCFG_W + `DTU_TEN_STORE] && storeValid);
			execEq[i] = fetchVaddr == triggerAddress[i*AW +: AW];
			dataEq[i] = dataVaddr == triggerAddress[i*AW +: AW];
			taskOk[i] = !triggerEventConfig[i*`DTU_TCFG_W + `DTU_TQUAL_BIT]
				|| triggerTaskIdentifier[i*TIDW +: TIDW] == currentTaskIdentifier;
			if (i % 2 == 0)
				rngEn[i] = triggerEventConfig[i*`DTU_TCFG_W + `DTU_TRNG_BIT];
		end
	end

	// Range compares, even member holds the lower bound
	always_comb begin
		execIn = '0;
		dataIn = '0;
		for (int p = 0; p < NTRIG; p += 2) begin
			execIn[p] = fetchVaddr >= triggerAddress[p*AW +: AW]
				&& fetchVaddr < triggerAddress[(p+1)*AW +: AW];
			dataIn[p] = dataVaddr >= triggerAddress[p*AW +: AW]
				&& dataVaddr < triggerAddress[(p+1)*AW +: AW];
		end
	end

	// Single hits, then enabled range pairs override both members
	always_comb begin
		hit = '0;
		actv = '0;
		for (int i = 0; i < NTRIG; i++) begin
			hit[i] = ((execSel[i] && execEq[i]) || (dataSel[i] && dataEq[i])) && taskOk[i];
			actv[i] = hit[i];
		end
		for (int p = 0; p < NTRIG; p += 2) begin
			if (rngEn[p]) begin
				actv[p] = ((execSel[p] && execIn[p]) || (dataSel[p] && dataIn[p])) && taskOk[p];
				actv[p+1] = 1'b0;
			end
		end
	end

	// Break-in counts once flops two and three agree high
	assign brkRise = st_reg.brkSync[2] && st_reg.brkSync[1];
	assign shortHit = (instrWord[15:0] & `DTU_SWDBG16_MASK) == `DTU_SWDBG16_CODE;
	assign longHit = (instrWord & `DTU_SWDBG32_MASK) == `DTU_SWDBG32_CODE;
	assign swHit = instrValid && (instrIsShort ? shortHit : longHit);
	assign inDbgWin = coreRegAddr >= `DTU_DBG_LO && coreRegAddr <= `DTU_DBG_HI;
	assign inPerfWin = coreRegAddr >= `DTU_PERF_LO && coreRegAddr <= `DTU_PERF_HI;
	assign crHit = coreRegAccess && !inDbgWin && !inPerfWin;

	// Event priority: break-in, trigger, register move, instruction
	always_comb begin
		cfg = '0;
		srcSel = `DTU_SRC_EXT;
		anyEvt = 1'b0;
		act = DTU_ACT_NONE;
		if (debugEnable) begin
			if (st_reg.brkPend && !nonCancelBusy) begin
				cfg = externalEventConfig;
				srcSel = `DTU_SRC_EXT;
				anyEvt = 1'b1;
			end else if (|actv) begin
				cfg = '0;
				for (int k = NTRIG-1; k >= 0; k--) begin
					if (actv[k]) begin
						cfg = triggerEventConfig[k*`DTU_TCFG_W +: `DTU_CFG_W];
						srcSel = `DTU_SRC_TRIG | 4'(k);
					end
				end
				anyEvt = 1'b1;
			end else if (crHit) begin
				cfg = coreRegAccessEventConfig;
				srcSel = `DTU_SRC_CREG;
				anyEvt = 1'b1;
			end else if (swHit) begin
				cfg = softwareEventConfig;
				srcSel = `DTU_SRC_SW;
				anyEvt = 1'b1;
			end
		end
		act = dtu_act_t'(cfg[`DTU_ACT_W-1:0]);
		if (act == DTU_ACT_DISABLE)
			anyEvt = 1'b0;
	end

	always_comb begin
		st_next = st_reg;

		// Three-stage break-in synchroniser
		st_next.brkSync = {st_reg.brkSync[1:0], breakIn};
		if (brkRise && !st_reg.brkPend && st_reg.state == DTU_ST_IDLE)
			st_next.brkPend = debugEnable;

		// Action pulses last one cycle
		st_next.evt = 1'b0;
		st_next.brkOut = 1'b0;
		st_next.halt = 1'b0;
		st_next.trap = 1'b0;
		st_next.irq = '0;
		st_next.cnt = 1'b0;

		// Record: a read clears, a new activation still sets
		if (recordRead)
			st_next.rec = '0;
		if (debugEnable)
			st_next.rec = st_next.rec | actv;

		// Break-in level tracking, one arm per rising edge
		case (st_reg.state)
			DTU_ST_IDLE: begin
				if (!brkRise)
					st_next.state = DTU_ST_IDLE;
			end
			DTU_ST_BUSY: begin
				if (!st_reg.brkSync[1])
					st_next.state = DTU_ST_IDLE;
			end
			default: st_next.state = DTU_ST_IDLE;
		endcase
		if (brkRise)
			st_next.state = DTU_ST_BUSY;

		// Status and actions of the selected event
		if (anyEvt) begin
			if (srcSel == `DTU_SRC_EXT)
				st_next.brkPend = 1'b0;
			st_next.evt = 1'b1;
			st_next.src = srcSel;
			st_next.posted = 1'b1;
			st_next.bbm = cfg[`DTU_BBM_BIT];
			st_next.brkOut = cfg[`DTU_BOD_BIT] || act == DTU_ACT_BRKOUT;
			st_next.cnt = cfg[`DTU_CNT_BIT];
			st_next.halt = act == DTU_ACT_HALT;
			st_next.trap = act == DTU_ACT_TRAP;
			st_next.suspInHalt = act == DTU_ACT_SUSPIN;
			case (act)
				DTU_ACT_IRQ0: st_next.irq = 4'h1;
				DTU_ACT_IRQ1: st_next.irq = 4'h2;
				DTU_ACT_IRQ2: st_next.irq = 4'h4;
				DTU_ACT_IRQ3: st_next.irq = 4'h8;
				default: st_next.irq = 4'h0;
			endcase
			if (!(act inside {DTU_ACT_IRQ0, DTU_ACT_IRQ1, DTU_ACT_IRQ2, DTU_ACT_IRQ3})) begin
				st_next.prevSusp = st_reg.susp;
				st_next.susp = cfg[`DTU_SUSP_BIT];
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_reg.brkSync <= 3'h0;
			st_reg.brkPend <= 1'b0;
			st_reg.rec <= '0;
			st_reg.evt <= 1'b0;
			st_reg.src <= '0;
			st_reg.posted <= 1'b0;
			st_reg.prevSusp <= 1'b0;
			st_reg.susp <= 1'b0;
			st_reg.brkOut <= 1'b0;
			st_reg.halt <= 1'b0;
			st_reg.trap <= 1'b0;
			st_reg.irq <= 4'h0;
			st_reg.cnt <= 1'b0;
			st_reg.suspInHalt <= 1'b0;
			st_reg.bbm <= 1'b0;
			st_reg.state <= DTU_ST_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from the state register
	assign accumulatedTriggerRecord = st_reg.rec;
	assign debugEvent = st_reg.evt;
	assign eventSource = st_reg.src;
	assign postedEvent = st_reg.posted;
	assign prevSuspend = st_reg.prevSusp;
	assign suspendOut = st_reg.susp;
	assign breakOut = st_reg.brkOut;
	assign haltReq = st_reg.halt;
	assign trapReq = st_reg.trap;
	assign bkptIrq = st_reg.irq;
	assign counterToggle = st_reg.cnt;
	assign suspendInHaltEn = st_reg.suspInHalt;
	assign breakBeforeMake = st_reg.bbm;
endmodule
`default_nettype wire

// [shared/dtu_defs.svh]
`ifndef DTU_DEFS_SVH
`define DTU_DEFS_SVH

// Debug register address window, inclusive
`define DTU_DBG_LO        16'hf000
`define DTU_DBG_HI        16'hfdff
// Performance counter register window, inclusive
`define DTU_PERF_LO       16'hfc00
`define DTU_PERF_HI       16'hfcff

// Software debug instruction encodings
`define DTU_SWDBG16_MASK  16'hffff
`define DTU_SWDBG16_CODE  16'ha000
`define DTU_SWDBG32_MASK  32'h0fffffff
`define DTU_SWDBG32_CODE  32'h0100000d

// Event configuration fields
`define DTU_CFG_W         8
`define DTU_ACT_W         4
`define DTU_SUSP_BIT      4
`define DTU_BOD_BIT       5
`define DTU_BBM_BIT       6
`define DTU_CNT_BIT       7

// Trigger configuration fields
`define DTU_TCFG_W        16
`define DTU_TEN_EXEC      8
`define DTU_TEN_LOAD      9
`define DTU_TEN_STORE     10
`define DTU_TRNG_BIT      11
`define DTU_TQUAL_BIT     12

// Event source codes in status
`define DTU_SRC_W         4
`define DTU_SRC_EXT       4'h0
`define DTU_SRC_SW        4'h1
`define DTU_SRC_CREG      4'h2
`define DTU_SRC_TRIG      4'h8

`endif

// [shared/dtu_pkg.sv]
package dtu_pkg;
	typedef enum logic [3:0] {
		DTU_ACT_NONE    = 4'h0,
		DTU_ACT_STATUS  = 4'h1,
		DTU_ACT_BRKOUT  = 4'h2,
		DTU_ACT_HALT    = 4'h3,
		DTU_ACT_TRAP    = 4'h4,
		DTU_ACT_IRQ0    = 4'h5,
		DTU_ACT_IRQ1    = 4'h6,
		DTU_ACT_IRQ2    = 4'h7,
		DTU_ACT_IRQ3    = 4'h8,
		DTU_ACT_SUSPIN  = 4'h9,
		DTU_ACT_DISABLE = 4'hf
	} dtu_act_t;
	typedef enum logic [1:0] {
		DTU_ST_IDLE = 2'b01,
		DTU_ST_BUSY = 2'b10
	} dtu_state_t;
endpackage

// [verif/dtu_on_chip_debug_support_model.sv]
`timescale 1ns/10ps
`default_nettype none
module dtu_on_chip_debug_support_model (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic fire,
	output logic      breakIn
);
	logic [3:0] holdCnt_reg;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			holdCnt_reg <= 4'h0;
		else if (fire)
			holdCnt_reg <= 4'h8;
		else if (holdCnt_reg != 4'h0)
			holdCnt_reg <= holdCnt_reg - 4'h1;
	end
	// Level held long enough to cross the synchroniser
	assign breakIn = (holdCnt_reg != 4'h0);
endmodule
`default_nettype wire

// [verif/dtu_debug_event_trigger_unit_props.sv]
`timescale 1ns/10ps
`default_nettype none
`include "dtu_defs.svh"
module dtu_debug_event_trigger_unit_props #(
	parameter int NTRIG = 8
) (
	input wire logic                  clk,
	input wire logic                  nrst,
	input wire logic                  debugEnable,
	input wire logic                  nonCancelBusy,
	input wire logic                  coreRegAccess,
	input wire logic [15:0]           coreRegAddr,
	input wire logic                  fetchValid,
	input wire logic                  loadValid,
	input wire logic                  storeValid,
	input wire logic                  recordRead,
	input wire logic [NTRIG-1:0]      accumulatedTriggerRecord,
	input wire logic                  debugEvent,
	input wire logic [`DTU_SRC_W-1:0] eventSource,
	input wire logic                  prevSuspend,
	input wire logic                  suspendOut,
	input wire logic                  breakOut,
	input wire logic                  haltReq,
	input wire logic                  trapReq,
	input wire logic [3:0]            bkptIrq,
	input wire logic                  counterToggle
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	dis_no_event_a: assert property (!debugEnable |=> !debugEvent)
		else $error("event while disabled");
	busy_no_ext_a: assert property (nonCancelBusy |=> !(debugEvent && eventSource == `DTU_SRC_EXT))
		else $error("break-in taken while busy");
	creg_window_a: assert property (coreRegAccess && coreRegAddr >= 16'hf000 && coreRegAddr <= 16'hfdff
		&& !fetchValid && !loadValid && !storeValid |=> !(debugEvent && eventSource == `DTU_SRC_CREG))
		else $error("event in debug register window");
	record_clear_a: assert property (recordRead && !fetchValid && !loadValid && !storeValid
		|=> accumulatedTriggerRecord == '0) else $error("record not cleared");
	record_hold_a: assert property (!recordRead && !fetchValid && !loadValid && !storeValid
		|=> $stable(accumulatedTriggerRecord)) else $error("record changed without cause");
	susp_shift_a: assert property (debugEvent && bkptIrq == 4'h0 |-> prevSuspend == $past(suspendOut))
		else $error("previous suspend not shifted");
	status_hold_a: assert property (!debugEvent |-> $stable(eventSource) && $stable(suspendOut))
		else $error("status moved without event");
	action_event_a: assert property (haltReq || trapReq || breakOut || counterToggle || bkptIrq != 4'h0
		|-> debugEvent) else $error("action without event");
	trig_cause_a: assert property (debugEvent && eventSource[3] |-> $past(fetchValid || loadValid || storeValid))
		else $error("trigger event without access");
endmodule
bind dtu_debug_event_trigger_unit dtu_debug_event_trigger_unit_props #(.NTRIG(NTRIG)) props_i (
	.clk, .nrst, .debugEnable, .nonCancelBusy, .coreRegAccess, .coreRegAddr, .fetchValid, .loadValid,
	.storeValid, .recordRead, .accumulatedTriggerRecord, .debugEvent, .eventSource, .prevSuspend,
	.suspendOut, .breakOut, .haltReq, .trapReq, .bkptIrq, .counterToggle
);
`default_nettype wire

// [verif/dtu_debug_event_trigger_unit_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "dtu_defs.svh"
module dtu_debug_event_trigger_unit_tb_top;
	logic clk, nrst, debugEnable, nonCancelBusy, fire, instrValid, instrIsShort, coreRegAccess, recordRead;
	logic fetchValid, loadValid, storeValid, breakIn, debugEvent, postedEvent, prevSuspend, suspendOut;
	logic breakOut, haltReq, trapReq, counterToggle, suspendInHaltEn, breakBeforeMake, expSusp, expPrev;
	logic [31:0] instrWord, fetchVaddr, dataVaddr;
	logic [15:0] coreRegAddr;
	logic [15:0] crAddr [0:5];
	logic [7:0] currentTaskIdentifier, externalEventConfig, softwareEventConfig, coreRegAccessEventConfig;
	logic [7:0] accumulatedTriggerRecord;
	logic [255:0] triggerAddress;
	logic [127:0] triggerEventConfig;
	logic [63:0] triggerTaskIdentifier;
	logic [3:0] eventSource, bkptIrq, act;
	int miscompares, cmp_count;
	dtu_on_chip_debug_support_model dtu_on_chip_debug_support_model_i (.clk, .nrst, .fire, .breakIn);
	dtu_debug_event_trigger_unit dtu_debug_event_trigger_unit_i (
		.clk, .nrst, .debugEnable, .breakIn, .nonCancelBusy, .instrValid, .instrWord, .instrIsShort,
		.coreRegAccess, .coreRegAddr, .fetchValid, .fetchVaddr, .loadValid, .storeValid, .dataVaddr,
		.currentTaskIdentifier, .externalEventConfig, .softwareEventConfig, .coreRegAccessEventConfig,
		.triggerAddress, .triggerEventConfig, .triggerTaskIdentifier, .recordRead, .accumulatedTriggerRecord,
		.debugEvent, .eventSource, .postedEvent, .prevSuspend, .suspendOut, .breakOut, .haltReq, .trapReq,
		.bkptIrq, .counterToggle, .suspendInHaltEn, .breakBeforeMake
	);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task give_verdict;
		if (miscompares == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input bit ok, input string msg);
		cmp_count++;
		if (!ok) begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask
	// Strobes last one cycle
	task tick;
		@(negedge clk);
		{instrValid, coreRegAccess, fetchValid, loadValid, storeValid, recordRead, fire} = '0;
	endtask
	task wait_event;
		for (int n = 0; n < 12 && debugEvent !== 1'b1; n++)
			tick();
		chk(debugEvent === 1'b1, "no event in time");
		if (debugEvent !== 1'b1)
			give_verdict();
	endtask
	initial begin
		{nrst, debugEnable, nonCancelBusy, fire, instrValid, instrIsShort, coreRegAccess, recordRead} = '0;
		{fetchValid, loadValid, storeValid, instrWord, fetchVaddr, dataVaddr, coreRegAddr} = '0;
		{currentTaskIdentifier, triggerAddress, triggerEventConfig, triggerTaskIdentifier, expSusp, expPrev} = '0;
		{softwareEventConfig, coreRegAccessEventConfig, externalEventConfig} = {8'h03, 8'h04, 8'h02};
		crAddr = '{16'h0100, 16'hefff, 16'hf000, 16'hfc80, 16'hfdff, 16'hfe00};
		repeat (3) @(negedge clk);
		nrst = 1'b1;
		chk({debugEvent, eventSource, suspendOut, accumulatedTriggerRecord} === '0, "reset state");
		for (int k = 0; k < 4; k++) begin
			{debugEnable, instrIsShort, instrValid} = {k[1], k[0], 1'b1};
			instrWord = k[0] ? 32'h0000a000 : 32'hf100000d;
			tick();
			chk(debugEvent === k[1] && haltReq === k[1], "debug instruction");
		end
		for (int i = 0; i < 6; i++) begin
			coreRegAddr = crAddr[i];
			coreRegAccess = 1'b1;
			tick();
			chk(debugEvent === (i < 2 || i == 5), "register move event");
			if (i < 2)
				chk(trapReq === 1'b1 && eventSource === `DTU_SRC_CREG, "register move action");
		end
		for (int i = 0; i < 11; i++) begin
			act = (i == 10) ? 4'hf : i[3:0];
			{coreRegAddr, coreRegAccessEventConfig, coreRegAccess} = {16'h0100, 3'h0, i[0], act, 1'b1};
			tick();
			if (act != 4'hf && (act < 4'h5 || act > 4'h8))
				{expPrev, expSusp} = {expSusp, i[0]};
			chk(debugEvent === (act != 4'hf) && haltReq === (act == 4'h3) && trapReq === (act == 4'h4)
				&& breakOut === (act == 4'h2), "action outputs");
			chk(bkptIrq === ((act >= 4'h5 && act <= 4'h8) ? (4'h1 << (act - 4'h5)) : 4'h0), "irq");
			chk(suspendOut === expSusp && prevSuspend === expPrev, "suspend status");
			chk(act == 4'hf || suspendInHaltEn === (act == 4'h9), "suspend-in halt");
		end
		{triggerAddress[96 +: 32], triggerEventConfig[48 +: 16], fetchVaddr} = {32'h4000, 16'h0103, 32'h4000};
		fetchValid = 1'b1;
		tick();
		chk(haltReq === 1'b1 && eventSource[3] === 1'b1, "exec trigger");
		{dataVaddr, loadValid} = {32'h4000, 1'b1};
		tick();
		chk(debugEvent === 1'b0, "load on exec trigger");
		{triggerAddress[160 +: 32], triggerEventConfig[80 +: 16], triggerTaskIdentifier[40 +: 8]} = {32'h8000, 16'h1c04, 8'h5a};
		dataVaddr = 32'h8000;
		for (int k = 0; k < 2; k++) begin
			{currentTaskIdentifier, storeValid} = {k[0] ? 8'h5a : 8'h5b, 1'b1};
			tick();
			chk(trapReq === k[0], "task qualified store");
		end
		chk(accumulatedTriggerRecord === 8'h28, "record bits");
		recordRead = 1'b1;
		tick();
		chk(accumulatedTriggerRecord === 8'h00, "record cleared");
		{triggerAddress[64 +: 64], triggerEventConfig[32 +: 32]} = {64'h00000200_00000100, 32'h0204_0a03};
		for (int i = 0; i < 4; i++) begin
			{dataVaddr, loadValid} = {(i == 3) ? 32'hff : (i == 2) ? 32'h200 : 32'h100 + 32'hff * i[31:0], 1'b1};
			tick();
			chk(haltReq === (i < 2) && trapReq === 1'b0, "range load");
		end
		chk(accumulatedTriggerRecord === 8'h04, "range record");
		{coreRegAccessEventConfig, coreRegAccess, instrValid} = {8'hc4, 1'b1, 1'b1};
		tick();
		chk(eventSource === `DTU_SRC_CREG && trapReq === 1'b1 && haltReq === 1'b0, "priority");
		chk(counterToggle === 1'b1 && breakBeforeMake === 1'b1 && postedEvent === 1'b1, "flags");
		{nonCancelBusy, fire} = 2'b11;
		for (int n = 0; n < 8; n++) begin
			tick();
			chk(debugEvent === 1'b0, "break-in while busy");
		end
		nonCancelBusy = 1'b0;
		wait_event();
		chk(eventSource === `DTU_SRC_EXT && breakOut === 1'b1, "break-in event");
		give_verdict();
	end
endmodule
`default_nettype wire
